/* File: tb/dnc_ctrl_monitor.sv */
`timescale 1ns/1ps
// checks strobe pacing and cycle shapes at the controller ports
module dnc_ctrl_monitor #(
    parameter int PAUSE_CYC = 20,
    parameter int REF_INT_CYC = 200
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire dnc_pkg::dnc_req_t req_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic init_done_o,
    input wire logic ras_n_o,
    input wire logic cas_n_o,
    input wire logic we_n_o
);
    logic take; // request accepted at this edge
    logic busy_r; // request in flight
    dnc_pkg::dnc_op_t op_r; // kind of that request
    logic ras_r; // row strobe one sample back
    int pause_r; // enabled cycles since reset, held at PAUSE_CYC
    int falls_r; // row strobe falls before init done
    int gap_r; // enabled cycles after init done since the last row strobe fall
    assign take = ce_i && req_valid_i && req_ready_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // helper counters and flags, reset to idle values
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_r <= 1'b0;
            op_r <= dnc_pkg::OP_READ;
            ras_r <= 1'b1;
            pause_r <= 0;
            falls_r <= 0;
            gap_r <= 0;
        end else begin
            busy_r <= take || (busy_r && !rsp_valid_o);
            op_r <= take ? req_i.op : op_r;
            ras_r <= ras_n_o;
            pause_r <= (ce_i && pause_r < PAUSE_CYC) ? pause_r + 1 : pause_r;
            falls_r <= (ras_r && !ras_n_o && !init_done_o) ? falls_r + 1 : falls_r;
            gap_r <= (ras_r && !ras_n_o) ? 0 : gap_r + int'(ce_i && init_done_o);
        end
    end

    a_pause_strobes_idle: assert property (
        pause_r < PAUSE_CYC |-> ras_n_o && cas_n_o) else $error("strobe active in pause");
    a_init_eight_refresh: assert property (
        $rose(init_done_o) |-> falls_r == dnc_pkg::INIT_CYCLES) else $error("init refresh count");
    a_idle_row_only: assert property (
        !busy_r && !ras_n_o |-> cas_n_o) else $error("column strobe low in row-only refresh");
    a_read_we_high: assert property (
        busy_r && (op_r == dnc_pkg::OP_READ || op_r == dnc_pkg::OP_NIB_READ) |-> we_n_o)
        else $error("write strobe low in a read");
    a_early_write: assert property (
        busy_r && (op_r == dnc_pkg::OP_WRITE || op_r == dnc_pkg::OP_NIB_WRITE)
        && $fell(cas_n_o) |-> !we_n_o) else $error("write strobe late in early write");
    a_rmw_late_we: assert property (
        busy_r && op_r == dnc_pkg::OP_RMW && $fell(cas_n_o) |-> we_n_o ##[1:4] !we_n_o)
        else $error("rmw write strobe not after column strobe");
    a_rmw_write_lead: assert property (
        busy_r && op_r == dnc_pkg::OP_RMW && $rose(cas_n_o) |-> !$past(we_n_o))
        else $error("write strobe lead too short");
    a_test_set_shape: assert property (
        busy_r && op_r == dnc_pkg::OP_TEST_SET && $fell(ras_n_o) && !cas_n_o |-> !we_n_o)
        else $error("test set without write strobe");
    a_ctest_shape: assert property (
        busy_r && op_r == dnc_pkg::OP_CTEST && $fell(ras_n_o) && !cas_n_o |-> we_n_o)
        else $error("counter test entered as test set");
    a_refresh_gap: assert property (
        gap_r <= REF_INT_CYC + 64) else $error("refresh gap too long");
endmodule // dnc_ctrl_monitor

bind dnc_ctrl dnc_ctrl_monitor #(.PAUSE_CYC(PAUSE_CYC), .REF_INT_CYC(REF_INT_CYC))
    dnc_ctrl_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o));

/* File: tb/dnc_ctrl_tb.sv */
`timescale 1ns/1ps
// self-checking bench: controller against the behavioural memory
module dnc_ctrl_tb;
    localparam int REFI = 200; // shortened refresh spacing
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic req_valid_i = 1'b0;
    dnc_pkg::dnc_req_t req_i = '0;
    logic dout_i, req_ready_o, rsp_valid_o, init_done_o, ras_n_o, cas_n_o, we_n_o, din_o;
    logic [3:0] rsp_data_o;
    logic [10:0] mux_address_o;
    logic mirror [256]; // expected cell contents
    logic [9:0] cnt_row = 10'h000; // expected refresh counter
    logic [7:0] exp_q[$]; // mask in the top nibble, data below
    logic [7:0] note; // oldest expectation
    logic idle_win = 1'b0; // counting idle refreshes
    int err_total = 0;
    int compares = 0;
    int seed = 53;
    int cyc = 0;
    int init_falls = 0;
    int idle_falls = 0;

    always #12.5 clk_i = ~clk_i;

    dnc_ctrl #(.PAUSE_CYC(20), .REF_INT_CYC(REFI)) dnc_ctrl_inst (.clk_i(clk_i),
        .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .dout_i(dout_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o),
        .cas_n_o(cas_n_o), .we_n_o(we_n_o), .mux_address_o(mux_address_o), .din_o(din_o));
    dnc_dram_model #(.ACC_NS(20)) dnc_dram_model_inst (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
        .we_n_i(we_n_o), .addr_i(mux_address_o), .din_i(din_o), .dout_o(dout_i));

    task automatic chk_rsp(input logic [3:0] exp, input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] rsp_data_o expected %h seen %h", exp, got);
        end
    endtask

    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // one request, held until the controller takes it
    task automatic send(input dnc_pkg::dnc_op_t op, input logic [10:0] row,
            input logic [10:0] col, input logic [3:0] wd, input logic [7:0] exp);
        @(posedge clk_i);
        #2;
        req_i = '{op: op, row: row, col: col, wdata: wd};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        while (!req_ready_o) @(negedge clk_i);
        @(posedge clk_i);
        exp_q.push_back(exp);
        #2;
        req_valid_i = 1'b0;
    endtask

    // answers are compared against the oldest note
    always @(negedge clk_i) begin
        if (rstn_i && rsp_valid_o) begin
            if (exp_q.size() == 0) chk_val("unexpected response", 0, 1);
            else begin
                note = exp_q.pop_front();
                chk_rsp(note[3:0] & note[7:4], rsp_data_o & note[7:4]);
            end
        end
    end

    // row strobe falls during init and in the idle window
    always @(negedge ras_n_o) begin
        if (rstn_i && !init_done_o) init_falls++;
        if (idle_win) idle_falls++;
    end

    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        logic [10:0] r, c;
        logic [3:0] w, e;
        logic [7:0] k;
        foreach (mirror[i]) mirror[i] = 1'b0;
        repeat (5) @(posedge clk_i);
        #2;
        rstn_i = 1'b1;
        while (!init_done_o) @(posedge clk_i);
        chk_val("init refreshes", dnc_pkg::INIT_CYCLES, init_falls);
        // early write, read back, read-modify-write, read back
        repeat (6) begin
            r = 11'($random(seed));
            c = 11'($random(seed));
            w = 4'($random(seed));
            k = {r[3:0], c[3:0]};
            send(dnc_pkg::OP_WRITE, r, c, w, 8'h00);
            mirror[k] = w[0];
            send(dnc_pkg::OP_READ, r, c, ~w, {7'h08, mirror[k]});
            send(dnc_pkg::OP_RMW, r, c, ~w, {7'h08, mirror[k]});
            mirror[k] = ~w[0];
            send(dnc_pkg::OP_READ, r, c, w, {7'h08, mirror[k]});
        end
        // nibble bursts from every start bit, wrap seen by a single read
        for (int j = 0; j < 4; j++) begin
            r = 11'($random(seed));
            c = {9'($random(seed)), 2'(j)};
            w = 4'($random(seed));
            send(dnc_pkg::OP_NIB_WRITE, r, c, w, 8'h00);
            for (int i = 0; i < 4; i++) mirror[{r[3:0], c[3:2], 2'(j + i)}] = w[3 - i];
            for (int i = 0; i < 4; i++) e[3 - i] = mirror[{r[3:0], c[3:2], 2'(j + i)}];
            send(dnc_pkg::OP_NIB_READ, r, c, 4'h0, {4'hf, e});
            send(dnc_pkg::OP_READ, r, {c[10:2], 2'(j + 1)}, 4'h0, {7'h08, w[2]});
        end
        send(dnc_pkg::OP_TEST_SET, 11'h000, 11'h000, 4'hf, 8'h00);
        cnt_row = cnt_row + 10'h001;
        // counter test: read the old bit, write a new one, read it back
        repeat (3) begin
            c = 11'($random(seed));
            w = 4'($random(seed));
            k = {cnt_row[3:0], c[3:0]};
            send(dnc_pkg::OP_CTEST, 11'($random(seed)), c, w, {7'h08, mirror[k]});
            mirror[k] = w[0];
            send(dnc_pkg::OP_READ, {1'b0, cnt_row}, c, ~w, {7'h08, mirror[k]});
            cnt_row = cnt_row + 10'h001;
        end
        // idle: periodic refresh alone must keep the rows alive
        idle_win = 1'b1;
        repeat (3 * REFI) @(posedge clk_i);
        idle_win = 1'b0;
        chk_val("idle refreshes", 1, 32'(idle_falls >= 2));
        while (exp_q.size() != 0) @(posedge clk_i);
        tally_and_finish();
    end
endmodule // dnc_ctrl_tb

/* File: tb/dnc_dram_model.sv */
`timescale 1ns/1ps
// behavioural nibble memory answering the controller's strobes
module dnc_dram_model #(
    parameter int ACC_NS = 0 // delay before read data shows
) (
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [dnc_pkg::ADDR_W-1:0] addr_i,
    input wire logic din_i,
    output logic dout_o
);
    logic mem [256]; // cells keyed by low row and column bits
    logic [9:0] ref_row = 10'h000; // internal refresh counter
    logic [3:0] row_q = 4'h0; // latched row, low bits
    logic [1:0] grp_q = 2'h0; // column bits above the nibble
    logic [1:0] nib = 2'h0; // bit within the nibble
    logic column_before_row_refresh = 1'b0; // column strobe led the row strobe
    logic seen = 1'b0; // column strobe rose since the row fall
    logic shown = 1'b0; // output carries valid data
    logic last = 1'b0; // last bit read out
    initial foreach (mem[i]) mem[i] = 1'b0;
    // off the bus the pin shows the inverse of the last bit
    assign dout_o = shown ? last : ~last;

    // row strobe fall: capture the row, or take it from the counter
    always @(negedge ras_n_i) begin
        column_before_row_refresh = !cas_n_i;
        seen = 1'b0;
        if (column_before_row_refresh) begin
            row_q = ref_row[3:0];
            ref_row = ref_row + 10'h001;
        end else begin
            row_q = addr_i[3:0];
            shown = 1'b0;
        end
    end

    // column strobe rise: output off, step to the next nibble bit
    always @(posedge cas_n_i) begin
        shown = 1'b0;
        if (!ras_n_i) begin
            nib = nib + 2'h1;
            seen = 1'b1;
        end
    end

    // column strobe fall: pick the column, then write or read
    always @(negedge cas_n_i) begin
        if (!ras_n_i && (!column_before_row_refresh || seen)) begin
            if (!seen || column_before_row_refresh) begin
                grp_q = addr_i[3:2];
                nib = addr_i[1:0];
            end
            if (!we_n_i) mem[{row_q, grp_q, nib}] = din_i;
            else begin
                last = mem[{row_q, grp_q, nib}];
                shown <= #(ACC_NS) 1'b1;
            end
        end
    end

    // late write strobe: read-modify-write, data taken at this edge
    always @(negedge we_n_i) begin
        if (!ras_n_i && !cas_n_i && (!column_before_row_refresh || seen)) mem[{row_q, grp_q, nib}] = din_i;
    end
endmodule // dnc_dram_model

/* File: verilog/dnc_ctrl.sv */
`timescale 1ns/1ps
// controller that drives the nibble mode memory through its strobes
module dnc_ctrl #(
    parameter int PAUSE_CYC = dnc_pkg::PAUSE_CYC,
    parameter int REF_INT_CYC = dnc_pkg::REF_INT_CYC,
    parameter bit USE_CBR_INIT = 1'b0,
    parameter bit USE_CBR = 1'b0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire dnc_pkg::dnc_req_t req_i,
    input wire logic dout_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [dnc_pkg::NIB_LEN-1:0] rsp_data_o,
    output logic init_done_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [dnc_pkg::ADDR_W-1:0] mux_address_o,
    output logic din_o
);
    localparam int TW = dnc_pkg::TMR_W;

    typedef enum logic [3:0] {
        ST_PAUSE, ST_PRE, ST_IDLE, ST_ROW, ST_ACT, ST_COL, ST_CAS, ST_NPRE,
        ST_WE, ST_RREF, ST_CBR_CAS, ST_CBR_RAS, ST_CT_CHI, ST_CT_CAS
    } dnc_state_t;

    dnc_state_t state_r, state_nxt; // sequencer state
    dnc_pkg::dnc_pins_t pins_r, pins_nxt; // registered pin levels
    dnc_pkg::dnc_req_t req_r, req_nxt; // request in progress
    logic acc_r, acc_nxt; // a user access is in progress
    logic [3:0] init_cnt_r, init_cnt_nxt; // init refreshes issued
    logic init_done_r, init_done_nxt;
    logic [dnc_pkg::ROW_CNT_W-1:0] ref_row_r, ref_row_nxt; // next row to refresh
    logic ref_pend_r, ref_pend_nxt; // refresh owed
    logic [dnc_pkg::NIB_LEN-1:0] rdata_r, rdata_nxt; // collected read bits
    logic [1:0] nib_idx_r, nib_idx_nxt; // bit within nibble
    logic rsp_valid_r, rsp_valid_nxt;
    logic ready_r, ready_nxt;
    logic tmr_load; // step timer load strobe
    logic [TW-1:0] tmr_val;
    logic tmr_done;
    logic ref_tick; // refresh spacing elapsed
    logic use_cbr; // refresh kind for the next refresh
    logic pause_armed_r; // pause loaded since reset

    // early write ops drive write strobe low before column strobe
    function automatic logic is_early(input dnc_pkg::dnc_op_t op);
        return (op == dnc_pkg::OP_WRITE) || (op == dnc_pkg::OP_NIB_WRITE);
    endfunction

    function automatic logic is_nib(input dnc_pkg::dnc_op_t op);
        return (op == dnc_pkg::OP_NIB_READ) || (op == dnc_pkg::OP_NIB_WRITE);
    endfunction

    // timer for the length of each step
    dnc_timer #(.W(TW)) u_step (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    // timer spacing refreshes so all rows are covered each period
    dnc_timer #(.W(TW)) u_ref (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .load_i(ref_tick),
        .value_i(TW'(REF_INT_CYC - 1)),
        .done_o(ref_tick)
    );

    assign use_cbr = init_done_r ? USE_CBR : USE_CBR_INIT;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        acc_nxt = acc_r;
        init_cnt_nxt = init_cnt_r;
        init_done_nxt = init_done_r;
        ref_row_nxt = ref_row_r;
        rdata_nxt = rdata_r;
        nib_idx_nxt = nib_idx_r;
        rsp_valid_nxt = 1'b0;
        tmr_load = 1'b0;
        tmr_val = '0;
        // a refresh tick sets the owed flag even while it is taken
        ref_pend_nxt = ref_pend_r | ref_tick;
        case (state_r)
            ST_PAUSE: begin
                // strobes stay high through the pause
                if (!pause_armed_r) begin
                    tmr_load = 1'b1;
                    tmr_val = TW'(PAUSE_CYC);
                end else if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!init_done_r || ref_pend_r) begin
                    // refresh first: init cycles or owed refresh
                    ref_pend_nxt = ref_tick;
                    if (!init_done_r) begin
                        init_cnt_nxt = init_cnt_r + 4'h1;
                    end
                    tmr_load = 1'b1;
                    if (use_cbr) begin
                        state_nxt = ST_CBR_CAS;
                    end else begin
                        state_nxt = ST_RREF;
                        tmr_val = TW'(dnc_pkg::RAS_CYC - 1);
                    end
                end else if (req_valid_i && ready_r) begin
                    // take the user request
                    req_nxt = req_i;
                    acc_nxt = 1'b1;
                    rdata_nxt = '0;
                    nib_idx_nxt = '0;
                    tmr_load = 1'b1;
                    if (req_i.op == dnc_pkg::OP_TEST_SET || req_i.op == dnc_pkg::OP_CTEST) begin
                        state_nxt = ST_CBR_CAS;
                    end else begin
                        state_nxt = ST_ROW;
                    end
                end
            end
            ST_ROW: begin
                // row address set up one cycle before the fall
                state_nxt = ST_ACT;
                tmr_load = 1'b1;
                tmr_val = TW'(dnc_pkg::RCD_CYC - 1);
            end
            ST_ACT: begin
                if (tmr_done) begin
                    state_nxt = ST_COL;
                    tmr_load = 1'b1;
                end
            end
            ST_COL: begin
                state_nxt = ST_CAS;
                tmr_load = 1'b1;
                tmr_val = TW'(dnc_pkg::ACC_CYC - 1);
            end
            ST_CAS: begin
                if (tmr_done) begin
                    // sample while column strobe is still low
                    rdata_nxt = {rdata_r[dnc_pkg::NIB_LEN-2:0], dout_i};
                    tmr_load = 1'b1;
                    if (is_nib(req_r.op) && nib_idx_r != 2'(dnc_pkg::NIB_LEN - 1)) begin
                        state_nxt = ST_NPRE;
                        nib_idx_nxt = nib_idx_r + 2'h1;
                        tmr_val = TW'(dnc_pkg::NCP_CYC - 1);
                    end else if (req_r.op == dnc_pkg::OP_RMW) begin
                        state_nxt = ST_WE;
                        tmr_val = TW'(dnc_pkg::CWL_CYC - 1);
                    end else begin
                        state_nxt = ST_PRE;
                        tmr_val = TW'(dnc_pkg::RP_CYC - 1);
                    end
                end
            end
            ST_NPRE: begin
                if (tmr_done) begin
                    state_nxt = ST_CAS;
                    tmr_load = 1'b1;
                    tmr_val = TW'(dnc_pkg::NIB_CAS_CYC - 1);
                end
            end
            ST_WE: begin
                // write strobe low for the lead time before both rises
                if (tmr_done) begin
                    state_nxt = ST_PRE;
                    tmr_load = 1'b1;
                    tmr_val = TW'(dnc_pkg::RP_CYC - 1);
                end
            end
            ST_RREF: begin
                if (tmr_done) begin
                    ref_row_nxt = ref_row_r + 1'b1;
                    state_nxt = ST_PRE;
                    tmr_load = 1'b1;
                    tmr_val = TW'(dnc_pkg::RP_CYC - 1);
                end
            end
            ST_CBR_CAS: begin
                // column strobe falls one cycle before the row strobe
                state_nxt = ST_CBR_RAS;
                tmr_load = 1'b1;
                tmr_val = TW'(dnc_pkg::RAS_CYC - 1);
            end
            ST_CBR_RAS: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (acc_r && req_r.op == dnc_pkg::OP_CTEST) begin
                        state_nxt = ST_CT_CHI;
                        tmr_val = TW'(dnc_pkg::NCP_CYC - 1);
                    end else begin
                        state_nxt = ST_PRE;
                        tmr_val = TW'(dnc_pkg::RP_CYC - 1);
                    end
                end
            end
            ST_CT_CHI: begin
                if (tmr_done) begin
                    state_nxt = ST_CT_CAS;
                    tmr_load = 1'b1;
                    tmr_val = TW'(dnc_pkg::FCAC_CYC - 1);
                end
            end
            ST_CT_CAS: begin
                if (tmr_done) begin
                    // read old bit, then write new one in the same access
                    rdata_nxt = {rdata_r[dnc_pkg::NIB_LEN-2:0], dout_i};
                    state_nxt = ST_WE;
                    tmr_load = 1'b1;
                    tmr_val = TW'(dnc_pkg::CWL_CYC - 1);
                end
            end
            ST_PRE: begin
                // both strobes high for row precharge
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                    rsp_valid_nxt = acc_r;
                    acc_nxt = 1'b0;
                    if (!init_done_r && init_cnt_r == 4'(dnc_pkg::INIT_CYCLES)) begin
                        init_done_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        ready_nxt = (state_nxt == ST_IDLE) && init_done_nxt && !ref_pend_nxt && !rsp_valid_nxt;
    end

    // pin levels follow the next state so they stay aligned with it
    always_comb begin
        pins_nxt = pins_r;
        pins_nxt.ras_n = 1'b1;
        pins_nxt.cas_n = 1'b1;
        pins_nxt.we_n = 1'b1;
        case (state_nxt)
            ST_ROW: begin
                pins_nxt.addr = req_nxt.row;
            end
            ST_ACT: begin
                pins_nxt.ras_n = 1'b0;
                pins_nxt.addr = req_nxt.row;
            end
            ST_COL, ST_CAS, ST_NPRE: begin
                // early write: write strobe low before column falls
                pins_nxt.ras_n = 1'b0;
                pins_nxt.cas_n = (state_nxt != ST_CAS);
                pins_nxt.addr = req_nxt.col;
                pins_nxt.we_n = !is_early(req_nxt.op);
                pins_nxt.din = is_nib(req_nxt.op)
                    ? req_nxt.wdata[2'(dnc_pkg::NIB_LEN - 1) - nib_idx_nxt]
                    : req_nxt.wdata[0];
            end
            ST_WE: begin
                // delayed write strobe after the bit was read
                pins_nxt.ras_n = 1'b0;
                pins_nxt.cas_n = 1'b0;
                pins_nxt.we_n = 1'b0;
                pins_nxt.din = req_nxt.wdata[0];
            end
            ST_RREF: begin
                // row-only refresh: column strobe high throughout
                pins_nxt.ras_n = 1'b0;
                pins_nxt.addr = {1'b0, ref_row_nxt};
            end
            ST_CBR_CAS, ST_CBR_RAS: begin
                pins_nxt.ras_n = (state_nxt == ST_CBR_CAS);
                pins_nxt.cas_n = 1'b0;
                pins_nxt.we_n = !(acc_nxt && req_nxt.op == dnc_pkg::OP_TEST_SET);
            end
            ST_CT_CHI, ST_CT_CAS: begin
                // second column strobe latches the column address
                pins_nxt.ras_n = 1'b0;
                pins_nxt.cas_n = (state_nxt == ST_CT_CHI);
                pins_nxt.addr = req_nxt.col;
                pins_nxt.din = req_nxt.wdata[0];
            end
            default: begin
                pins_nxt.ras_n = 1'b1;
            end
        endcase
    end

    // register all state, frozen while enable is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_PAUSE;
            pins_r <= dnc_pkg::PINS_RST;
            req_r <= '0;
            acc_r <= 1'b0;
            init_cnt_r <= '0;
            init_done_r <= 1'b0;
            ref_row_r <= '0;
            ref_pend_r <= 1'b0;
            rdata_r <= '0;
            nib_idx_r <= '0;
            rsp_valid_r <= 1'b0;
            ready_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            req_r <= req_nxt;
            acc_r <= acc_nxt;
            init_cnt_r <= init_cnt_nxt;
            init_done_r <= init_done_nxt;
            ref_row_r <= ref_row_nxt;
            ref_pend_r <= ref_pend_nxt;
            rdata_r <= rdata_nxt;
            nib_idx_r <= nib_idx_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            ready_r <= ready_nxt;
        end
    end

    // set once the pause has been loaded
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pause_armed_r <= 1'b0;
        end else if (ce_i) begin
            pause_armed_r <= 1'b1;
        end
    end

    assign req_ready_o = ready_r;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_data_o = rdata_r;
    assign init_done_o = init_done_r;
    assign ras_n_o = pins_r.ras_n;
    assign cas_n_o = pins_r.cas_n;
    assign we_n_o = pins_r.we_n;
    assign mux_address_o = pins_r.addr;
    assign din_o = pins_r.din;
endmodule // dnc_ctrl

/* File: verilog/dnc_pkg.sv */
package dnc_pkg;
    localparam int CLK_MHZ = 40; // system clock rate
    localparam int ADDR_W = 11; // multiplexed address width
    localparam int ROW_CNT_W = 10; // refresh row counter width
    localparam int NIB_LEN = 4; // bits in one nibble burst
    localparam int INIT_CYCLES = 8; // refresh cycles at power-up
    localparam int REF_ROWS = 1024; // rows per refresh period
    localparam int T_PAUSE_US = 200; // power-up pause
    localparam int T_REF_MS = 128; // refresh period
    localparam int T_RAS_NS = 80; // row strobe low time
    localparam int T_RP_NS = 50; // row precharge
    localparam int T_RAC_NS = 80; // access from row strobe
    localparam int T_RCD_NS = 20; // row to column strobe delay
    localparam int T_CWL_NS = 20; // write to column / row lead
    localparam int T_NCP_NS = 10; // nibble column precharge
    localparam int T_NPA_NS = 35; // nibble access from precharge
    localparam int T_NC_NS = 40; // nibble cycle time
    localparam int T_FCAC_NS = 60; // counter test column access

    // least time in ns to whole cycles, rounded up, at least one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PAUSE_CYC = T_PAUSE_US * CLK_MHZ; // pause in cycles
    // longest refresh spacing, rounded down
    localparam int REF_INT_CYC = (T_REF_MS * 1000 * CLK_MHZ) / REF_ROWS;
    localparam int RAS_CYC = cyc_min(T_RAS_NS);
    localparam int RP_CYC = cyc_min(T_RP_NS);
    localparam int RCD_CYC = cyc_min(T_RCD_NS);
    localparam int CWL_CYC = cyc_min(T_CWL_NS);
    localparam int NCP_CYC = cyc_min(T_NCP_NS);
    localparam int FCAC_CYC = cyc_min(T_FCAC_NS);
    // column strobe low until row access time has passed (row, col lead 2)
    localparam int ACC_CYC = cyc_min(T_RAC_NS) - 2;
    // nibble column low so precharge plus low covers access and cycle time
    localparam int NIB_CAS_CYC = (cyc_min(T_NPA_NS) > cyc_min(T_NC_NS))
        ? cyc_min(T_NPA_NS) - NCP_CYC : cyc_min(T_NC_NS) - NCP_CYC;
    localparam int TMR_W = 16; // step timer width

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_RMW, OP_NIB_READ, OP_NIB_WRITE, OP_TEST_SET, OP_CTEST
    } dnc_op_t;

    // user request
    typedef struct packed {
        dnc_op_t op;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [NIB_LEN-1:0] wdata;
    } dnc_req_t;

    // memory pins driven by the controller
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic din;
    } dnc_pins_t;

    localparam dnc_pins_t PINS_RST = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
        addr: 11'h000, din: 1'b0};
endpackage

/* File: verilog/dnc_timer.sv */
`timescale 1ns/1ps
// loadable down counter, done while it stands at zero
module dnc_timer #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic done_o
);
    logic [W-1:0] cnt_r; // remaining cycles
    logic [W-1:0] cnt_nxt;

    // load wins, else count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = value_i;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // register, frozen while enable is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done_o = (cnt_r == '0);
endmodule // dnc_timer
